// ### verification/tb_wct_counter16.sv
// Purpose: self-checking bench of the wide counter control
// Assumes: ack one cycle after the taking edge
// Notes: expectations come from a byte model of the control register
`timescale 1ns/1ps
`include "wct_defs.svh"
module tb_wct_counter16;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic [31:0] rd;
  logic        wb_ack_o;
  logic        demod_in = 1'b0;
  logic        port_out_value = 1'b0;
  logic        shared_port_pin;
  logic        wide_counter_output;
  logic        irq;
  logic [7:0]  exp_ctl;
  int          num_errors = 0;
  int          n_checks = 0;
  int          cycles = 0;
  int          t0;
  int          rl;
  int          dv;
  always #12.5 sys_clk = ~sys_clk;
  wct_counter16 dut (.sys_clk(sys_clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .demod_in(demod_in), .port_out_value(port_out_value),
    .shared_port_pin(shared_port_pin), .wide_counter_output(wide_counter_output), .irq(irq));
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      results();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic wait_flag();
    t0 = cycles;
    do wb(1'b0, `WCT_OFS_CTRL, 32'h0); while (rd[5] !== 1'b1 && cycles - t0 < 400);
  endtask
  initial begin
    void'($urandom(32'h087d1433));
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    rchk(`WCT_OFS_CTRL, 32'h00);
    rchk(`WCT_OFS_RELOAD_LO, 32'hFF);
    rchk(8'h30, 32'h0);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      port_out_value <= 1'($urandom);
      wb(1'b1, `WCT_OFS_CTRL, 32'(i % 2));
      repeat (3) @(posedge sys_clk);
      chk(32'(shared_port_pin), 32'(i % 2 ? 1'b0 : port_out_value));
    end
    $display("routing test done");
    for (int k = 0; k < 4; k++) begin
      rl = 2 + $urandom_range(3);
      dv = 1 << k;
      wb(1'b1, `WCT_OFS_RELOAD_LO, 32'(rl));
      wb(1'b1, `WCT_OFS_RELOAD_HI, 32'h0);
      wb(1'b1, `WCT_OFS_IRQ_MASK, 32'h1);
      exp_ctl = {2'b11, 1'b0, 2'(k), 1'b0, 1'(k % 2), 1'b0};
      wb(1'b1, `WCT_OFS_CTRL, 32'(exp_ctl));
      wait_flag();
      chk(32'(cycles - t0 >= rl * dv && cycles - t0 <= (rl + 2) * dv + 8), 32'h1);
      chk(rd, 32'(exp_ctl & 8'h7F | 8'h20));
      chk(32'(irq), 32'(k % 2));
      chk(32'(wide_counter_output), 32'((k + 1) % 2));
      wb(1'b1, `WCT_OFS_CTRL, 32'(exp_ctl & 8'h5F));
      rchk(`WCT_OFS_CTRL, 32'(exp_ctl & 8'h5F | 8'h20));
      wb(1'b1, `WCT_OFS_CTRL, 32'(exp_ctl & 8'h5F | 8'h20));
      rchk(`WCT_OFS_CTRL, 32'(exp_ctl & 8'h5F));
      wb(1'b1, `WCT_OFS_IRQ_STATUS, 32'h3);
      rchk(`WCT_OFS_IRQ_STATUS, 32'h0);
    end
    wb(1'b1, `WCT_OFS_CTRL, 32'h80);
    wait_flag();
    chk(rd, 32'hA0);
    // stop first, so no terminal count can set the flag again while it is cleared
    wb(1'b1, `WCT_OFS_CTRL, 32'h00);
    wb(1'b1, `WCT_OFS_CTRL, 32'h20);
    rchk(`WCT_OFS_CTRL, 32'h0);
    $display("timeout test done");
    wb(1'b1, `WCT_OFS_RELOAD_LO, 32'hFF);
    wb(1'b1, `WCT_OFS_RELOAD_HI, 32'hFF);
    wb(1'b1, `WCT_OFS_MODE, 32'h1);
    rchk(`WCT_OFS_MODE, 32'h1);
    wb(1'b1, `WCT_OFS_IRQ_MASK, 32'h2);
    for (int m = 0; m < 3; m++) begin
      wb(1'b1, `WCT_OFS_CTRL, m == 0 ? 32'h84 : m == 1 ? 32'hC4 : 32'h80);
      repeat (3) begin
        repeat (6 + $urandom_range(8)) @(posedge sys_clk);
        demod_in <= ~demod_in;
      end
      repeat (10) @(posedge sys_clk);
      rchk(`WCT_OFS_IRQ_STATUS, m == 0 ? 32'h2 : 32'h0);
      chk(32'(irq), 32'(m == 0));
      if (m == 0) begin
        wb(1'b0, `WCT_OFS_CAPTURE_LO, 32'h0);
        chk(32'(rd >= 32'h3 && rd <= 32'hF), 32'h1);
        rchk(`WCT_OFS_CAPTURE_HI, 32'h0);
      end
      wb(1'b1, `WCT_OFS_MODE, 32'h0);
      rchk(`WCT_OFS_MODE, 32'h1);
      wb(1'b1, `WCT_OFS_CTRL, 32'h0);
      wb(1'b1, `WCT_OFS_IRQ_STATUS, 32'h3);
    end
    wb(1'b1, `WCT_OFS_MODE, 32'h0);
    rchk(`WCT_OFS_MODE, 32'h0);
    wb(1'b1, `WCT_OFS_IRQ_MASK, 32'h0);
    repeat (4) @(posedge sys_clk);
    chk(32'(irq), 32'h0);
    $display("capture test done");
    results();
  end
endmodule
bind wct_counter16 wct_counter16_monitor mon (.sys_clk(sys_clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .port_out_value(port_out_value),
  .shared_port_pin(shared_port_pin), .wide_counter_output(wide_counter_output), .irq(irq));

// ### verification/wct_counter16_monitor.sv
// Purpose: bus, pin and interrupt checks on the wide counter control ports
// Assumes: one ack per request, writes take effect at the taking edge
// Notes: keeps a shadow of the control byte written by software
`timescale 1ns/1ps
`include "wct_defs.svh"
module wct_counter16_monitor (
  // system
  input wire logic        sys_clk,
  input wire logic        reset,
  // wishbone
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // pins
  input wire logic        port_out_value,
  input wire logic        shared_port_pin,
  input wire logic        wide_counter_output,
  input wire logic        irq
);
  logic       take;
  logic       wr_ok;
  logic       unmapped;
  logic [7:0] ctl_m;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_ok = take && wb_we_i && wb_sel_i[0];
  assign unmapped = !(wb_adr_i inside {`WCT_OFS_PORT_CFG, `WCT_OFS_CTRL, `WCT_OFS_RELOAD_LO, `WCT_OFS_RELOAD_HI,
    `WCT_OFS_CAPTURE_LO, `WCT_OFS_CAPTURE_HI, `WCT_OFS_MODE, `WCT_OFS_IRQ_STATUS, `WCT_OFS_IRQ_MASK});
  always_ff @(posedge sys_clk) begin
    if (reset)
      ctl_m <= 8'h00;
    else if (wr_ok && wb_adr_i == `WCT_OFS_CTRL)
      ctl_m <= wb_dat_i[7:0];
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence s_take;
    take;
  endsequence
  a_ack_follows: assert property (s_take |=> wb_ack_o) else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  a_ack_cause: assert property (wb_ack_o |-> $past(take)) else $error("ack without request");
  a_reset_quiet: assert property (disable iff (1'b0) reset |=> !irq && !wb_ack_o) else $error("busy in reset");
  a_pin_port: assert property (!$past(reset) && !$past(ctl_m[0]) |-> shared_port_pin == $past(port_out_value))
    else $error("pin not port value");
  a_pin_counter: assert property ($past(ctl_m[0]) && $stable(wide_counter_output) && !$past(reset)
    |-> shared_port_pin == wide_counter_output) else $error("pin not counter");
  a_read_unmapped: assert property (wb_ack_o && $past(!wb_we_i && unmapped) |-> wb_dat_o == 32'h0)
    else $error("unmapped read nonzero");
  a_ctrl_fields: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i == `WCT_OFS_CTRL)
    |-> (wb_dat_o[7:0] & 8'h5F) == (ctl_m & 8'h5F)) else $error("control readback");
  a_mask_quiet: assert property (wr_ok && wb_adr_i == `WCT_OFS_IRQ_MASK && wb_dat_i[1:0] == 2'h0
    |-> ##2 !irq [*2]) else $error("masked irq");
endmodule

// ### verilog/wct_counter16.sv
// Purpose: 16-bit counter control and status with a classic wishbone slave
// Assumes: single clock sys_clk at 40 MHz, synchronous active-high reset
// Notes: counter clock is an enable pulse from a prescaler
// Operation
// - route bit 0 gives the shared port pin its port value, 1 gives it the counter output, default 0.
// - timeout interrupt enable lets a timeout raise a request, default off.
// - capture interrupt enable lets a capture raise a request.
// - a two-bit clock select picks the system clock or a divided copy, undivided by default.
// - the timeout flag reads 1 after a timeout, write 1 clears it, write 0 leaves it.
// - in transmit mode the behaviour bit picks modulo-N reload at 0 and single pass at 1.
// - in demodulation mode the behaviour bit lets the counter see edges at 0 and ignore them at 1.
// - the enable bit reads the running state, write 1 starts and write 0 stops, default stopped.
// - the control decode follows whether transmit or demodulation mode is active.
// - the timeout flag sets each time the counter reaches terminal count.
`timescale 1ns/1ps
`include "wct_defs.svh"
module wct_counter16 #(
  parameter int WIDTH = 16
) (
  // system
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // pins
  input  wire logic        demod_in,
  input  wire logic        port_out_value,
  output logic             shared_port_pin,
  output logic             wide_counter_output,
  // interrupt
  output logic             irq
);
  // the field layout and reload constants are 16 bits wide
  if (WIDTH != 16) begin : g_width_check
    $error("WIDTH must be 16");
  end

  wct_pkg::wct_ctrl_t ctrl_reg;
  wct_pkg::wct_mode_t mode_reg;
  logic [7:0]         port_config_write_reg;
  logic [15:0]        reload_reg;
  logic [15:0]        count_reg;
  logic [15:0]        capture_reg;
  logic [1:0]         irq_status_reg;
  logic [1:0]         irq_mask_reg;
  logic [2:0]         presc_reg;
  logic [2:0]         in_sync_reg;
  logic               edge_seen_reg;
  logic               out_reg;
  logic               ack_reg;
  logic [31:0]        rdata_reg;

  logic wr_req;
  logic rd_req;
  logic tick;
  logic terminal;
  logic in_edge;
  logic capture_ev;
  logic timeout_ev;

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    hit = (adr == ofs);
  endfunction

  assign wr_req = wb_cyc_i && wb_stb_i && wb_we_i && !ack_reg && wb_sel_i[0];
  assign rd_req = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_reg;

  // prescaler: divide by 1, 2, 4, 8
  always_ff @(posedge sys_clk) begin
    if (reset || !ctrl_reg.enable) begin
      presc_reg <= 3'h0;
    end else begin
      presc_reg <= presc_reg + 3'h1;
    end
  end

  always_comb begin
    unique case (ctrl_reg.clksel)
      2'b00:   tick = ctrl_reg.enable;
      2'b01:   tick = ctrl_reg.enable && (presc_reg[0] == 1'b1);
      2'b10:   tick = ctrl_reg.enable && (presc_reg[1:0] == 2'h3);
      2'b11:   tick = ctrl_reg.enable && (presc_reg == 3'h7);
    endcase
  end

  // pin input synchroniser
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      in_sync_reg <= 3'h0;
    end else begin
      in_sync_reg <= {in_sync_reg[1:0], demod_in};
    end
  end

  assign in_edge    = (in_sync_reg[2] != in_sync_reg[1]);
  assign terminal   = tick && (count_reg == 16'h0000);
  // behaviour bit gates edges in demodulation mode
  assign capture_ev = (mode_reg == wct_pkg::WCT_DEMOD) && ctrl_reg.enable && !ctrl_reg.single
                      && in_edge && edge_seen_reg;
  assign timeout_ev = terminal;

  // counter
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      count_reg     <= `WCT_RELOAD_RESET;
      edge_seen_reg <= 1'b0;
      capture_reg   <= 16'h0000;
    end else if (!ctrl_reg.enable) begin
      count_reg     <= reload_reg;
      edge_seen_reg <= 1'b0;
    end else if (mode_reg == wct_pkg::WCT_DEMOD) begin
      if (capture_ev) begin
        capture_reg <= ~count_reg;
        count_reg   <= reload_reg;
      end else if (in_edge && !ctrl_reg.single) begin
        edge_seen_reg <= 1'b1;
      end else if (terminal) begin
        count_reg <= reload_reg;
      end else if (tick && edge_seen_reg) begin
        count_reg <= count_reg - 16'h0001;
      end
    end else if (terminal) begin
      count_reg <= reload_reg;
    end else if (tick) begin
      count_reg <= count_reg - 16'h0001;
    end
  end

  // counter output toggles on terminal count in transmit mode
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      out_reg <= 1'b0;
    end else if (mode_reg == wct_pkg::WCT_TRANSMIT && terminal) begin
      out_reg <= !out_reg;
    end
  end

  // control register
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ctrl_reg <= wct_pkg::wct_ctrl_t'(`WCT_CTRL_RESET);
    end else begin
      if (wr_req && hit(wb_adr_i, `WCT_OFS_CTRL)) begin
        ctrl_reg.route  <= wb_dat_i[`WCT_BIT_ROUTE];
        ctrl_reg.to_ie  <= wb_dat_i[`WCT_BIT_TO_IE];
        ctrl_reg.cap_ie <= wb_dat_i[`WCT_BIT_CAP_IE];
        ctrl_reg.clksel <= wb_dat_i[`WCT_BIT_CLKSEL_LO +: 2];
        ctrl_reg.single <= wb_dat_i[`WCT_BIT_SINGLE];
        ctrl_reg.enable <= wb_dat_i[`WCT_BIT_ENABLE];
      end
      // single pass stops after terminal count, unless software writes the control register in the same cycle
      if (terminal && ctrl_reg.single && mode_reg == wct_pkg::WCT_TRANSMIT
          && !(wr_req && hit(wb_adr_i, `WCT_OFS_CTRL))) begin
        ctrl_reg.enable <= 1'b0;
      end
      // set wins over write-one clear
      if (timeout_ev) begin
        ctrl_reg.timeout <= 1'b1;
      end else if (wr_req && hit(wb_adr_i, `WCT_OFS_CTRL) && wb_dat_i[`WCT_BIT_TIMEOUT]) begin
        ctrl_reg.timeout <= 1'b0;
      end
    end
  end

  // other writable registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      port_config_write_reg <= 8'h00;
      reload_reg            <= `WCT_RELOAD_RESET;
      mode_reg              <= wct_pkg::WCT_TRANSMIT;
      irq_mask_reg          <= 2'h0;
    end else if (wr_req) begin
      if (hit(wb_adr_i, `WCT_OFS_PORT_CFG))  port_config_write_reg <= wb_dat_i[7:0];
      if (hit(wb_adr_i, `WCT_OFS_RELOAD_LO)) reload_reg[7:0]       <= wb_dat_i[7:0];
      if (hit(wb_adr_i, `WCT_OFS_RELOAD_HI)) reload_reg[15:8]      <= wb_dat_i[7:0];
      // mode change while running is ignored
      if (hit(wb_adr_i, `WCT_OFS_MODE) && !ctrl_reg.enable) begin
        mode_reg <= wct_pkg::wct_mode_t'(wb_dat_i[0]);
      end
      if (hit(wb_adr_i, `WCT_OFS_IRQ_MASK))  irq_mask_reg          <= wb_dat_i[1:0];
    end
  end

  // interrupt status, sticky, write one to clear, set wins
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irq_status_reg <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == `WCT_IRQ_TIMEOUT && timeout_ev && ctrl_reg.to_ie)
            || (i == `WCT_IRQ_CAPTURE && capture_ev && ctrl_reg.cap_ie)) begin
          irq_status_reg[i] <= 1'b1;
        end else if (wr_req && hit(wb_adr_i, `WCT_OFS_IRQ_STATUS) && wb_dat_i[i]) begin
          irq_status_reg[i] <= 1'b0;
        end
      end
    end
  end

  // bus answer, one cycle after the request
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
      if (rd_req) begin
        unique case (wb_adr_i)
          `WCT_OFS_CTRL:       rdata_reg <= {24'h000000, ctrl_reg};
          `WCT_OFS_RELOAD_LO:  rdata_reg <= {24'h000000, reload_reg[7:0]};
          `WCT_OFS_RELOAD_HI:  rdata_reg <= {24'h000000, reload_reg[15:8]};
          `WCT_OFS_CAPTURE_LO: rdata_reg <= {24'h000000, capture_reg[7:0]};
          `WCT_OFS_CAPTURE_HI: rdata_reg <= {24'h000000, capture_reg[15:8]};
          `WCT_OFS_MODE:       rdata_reg <= {31'h00000000, mode_reg};
          `WCT_OFS_IRQ_STATUS: rdata_reg <= {30'h00000000, irq_status_reg};
          `WCT_OFS_IRQ_MASK:   rdata_reg <= {30'h00000000, irq_mask_reg};
          default:             rdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  // pin routing
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      shared_port_pin     <= 1'b0;
      wide_counter_output <= 1'b0;
      irq                 <= 1'b0;
    end else begin
      shared_port_pin     <= ctrl_reg.route ? out_reg : port_out_value;
      wide_counter_output <= out_reg;
      irq                 <= |(irq_status_reg & irq_mask_reg);
    end
  end
endmodule

// ### verilog/wct_defs.svh
// Purpose: offsets, field positions, reset values and interrupt bit indices of the wide counter control
// Assumes: byte-wide register, one per aligned bus word
// Notes: none
`ifndef WCT_DEFS_SVH
`define WCT_DEFS_SVH
`define WCT_OFS_PORT_CFG      8'h00
`define WCT_OFS_CTRL          8'h08
`define WCT_OFS_RELOAD_LO     8'h10
`define WCT_OFS_RELOAD_HI     8'h14
`define WCT_OFS_CAPTURE_LO    8'h18
`define WCT_OFS_CAPTURE_HI    8'h1C
`define WCT_OFS_MODE          8'h20
`define WCT_OFS_IRQ_STATUS    8'h24
`define WCT_OFS_IRQ_MASK      8'h28
`define WCT_BIT_ROUTE         0
`define WCT_BIT_TO_IE         1
`define WCT_BIT_CAP_IE        2
`define WCT_BIT_CLKSEL_LO     3
`define WCT_BIT_TIMEOUT       5
`define WCT_BIT_SINGLE        6
`define WCT_BIT_ENABLE        7
`define WCT_CTRL_RESET        8'h00
`define WCT_RELOAD_RESET      16'hFFFF
`define WCT_IRQ_TIMEOUT       0
`define WCT_IRQ_CAPTURE       1
`endif

// ### verilog/wct_pkg.sv
// Purpose: types of the wide counter control
// Assumes: constants live in wct_defs.svh
// Notes: none
package wct_pkg;
  typedef struct packed {
    logic       enable;
    logic       single;
    logic       timeout;
    logic [1:0] clksel;
    logic       cap_ie;
    logic       to_ie;
    logic       route;
  } wct_ctrl_t;
  typedef enum logic {WCT_TRANSMIT, WCT_DEMOD} wct_mode_t;
endpackage
